// >>> src/hpw_port.v
// Purpose: board-side receiver for host-to-board byte writes over the parallel link
// Assumes: select, request and data arrive with no relation to mclk_i
// Notes: captured byte is offered to local logic with a one-cycle strobe
//        data bus is not synchronised; it is sampled on the edge that sees
//        request high, which is safe only while the host holds the byte
//        a select change during acknowledge is ignored until idle
//        the switch is re-read every clock, so a new strap takes effect at idle
// How it works
// R1 - The board answers only when the host select lines equal its switch address.
// R2 - Every link control line is active high.
// R3 - The handshake advances only on seen level changes, never on timing.
// R4 - The host drives and holds the target address on the select lines for the whole cycle.
// R5 - The host latches its byte before raising request, with its buffer off.
// R6 - While request is high the host drives the byte onto the data bus.
// R7 - On request the selected board captures the byte, then raises acknowledge until request drops.
// R8 - The host drops request on acknowledge, releasing the data bus.
// R9 - When request drops the board drops acknowledge, ending the cycle.
// R10 - Select and request pass two flip-flops before the board acts on them.
`timescale 1ns/1ps
`default_nettype none
`include "hpw_defines.vh"
module hpw_port (
    input  wire                   mclk_i,
    input  wire                   rst_i,
    input  wire [`HPW_SEL_W-1:0]  board_address_switch_i,
    input  wire [`HPW_SEL_W-1:0]  board_select_lines_i,
    input  wire                   host_request_i,
    input  wire [`HPW_DATA_W-1:0] host_data_i,
    output reg                    board_write_acknowledge_o,
    output reg  [`HPW_DATA_W-1:0] rx_data_o,
    output reg                    rx_valid_o,
    output wire                   busy_o
);
    // state codes, binary
    localparam ST_IDLE    = `HPW_ST_IDLE;
    localparam ST_CAPTURE = `HPW_ST_CAPTURE;
    localparam ST_ACK     = `HPW_ST_ACK;

    // one synchroniser lane per select line plus one for request
    localparam SYNC_W     = `HPW_SEL_W + 1;

    // synchronised link levels
    wire [SYNC_W-1:0]      sync_in;
    wire [`HPW_SEL_W-1:0]  sel_s;
    wire                   req_s;

    // board address compare
    reg  [`HPW_SEL_W-1:0]  my_addr;
    wire [`HPW_SEL_W-1:0]  bit_match;
    wire                   selected;

    // handshake state
    reg  [1:0]             state;
    reg  [1:0]             next_state;
    wire                   in_idle;
    wire                   req_seen;
    wire                   req_gone;
    wire                   take_byte;

    // next values of the registered outputs
    reg                    next_ack;
    reg  [`HPW_DATA_W-1:0] next_rx_data;
    reg                    next_rx_valid;

    // select and request share one synchroniser so they age together
    hpw_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .async_i ({host_request_i, board_select_lines_i}),
        .sync_o  (sync_in)
    ); // R10

    assign sel_s = sync_in[`HPW_SEL_W-1:0];
    assign req_s = sync_in[`HPW_SEL_W]; // R2

    // switch sampled by clock so a strap change never races reset
    always @(posedge mclk_i) begin
        if (rst_i) begin
            my_addr <= `HPW_ADDR_RST;
        end else begin
            my_addr <= board_address_switch_i;
        end
    end

    // one comparator per select line
    genvar b;
    generate
        for (b = 0; b < `HPW_SEL_W; b = b + 1) begin : addr_cmp
            assign bit_match[b] = (sel_s[b] == my_addr[b]);
        end
    endgenerate

    assign selected = &bit_match; // R1

    // level decodes that drive the state machine
    assign in_idle   = (state == ST_IDLE);
    assign req_seen  = req_s && selected; // R1
    assign req_gone  = !req_s; // R9
    assign busy_o    = !in_idle;

    // the idle to capture step is the one edge that takes the byte
    assign take_byte = in_idle && req_seen; // R7

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                // request is seen two cycles after the host drove the bus
                if (req_seen) begin
                    next_state = ST_CAPTURE; // R7
                end
            end
            ST_CAPTURE: begin
                next_state = ST_ACK; // R7
            end
            ST_ACK: begin
                // select changes here are ignored until request drops
                if (req_gone) begin
                    next_state = ST_IDLE; // R9
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // registered outputs follow the step the machine is taking
    always @* begin
        next_ack      = 1'b0;
        next_rx_data  = rx_data_o;
        next_rx_valid = 1'b0;
        case (state)
            ST_IDLE: begin
                if (take_byte) begin
                    // only safe because the host holds the byte while request is high
                    next_rx_data  = host_data_i; // R6
                    next_rx_valid = 1'b1; // R7
                end
            end
            ST_CAPTURE: begin
                // ack only after the byte is held
                next_ack = 1'b1; // R7
            end
            ST_ACK: begin
                // ack stands until the seen request drops, never on a count
                next_ack = !req_gone; // R3
            end
            default: begin
                next_ack = 1'b0;
            end
        endcase
    end

    // handshake state register
    always @(posedge mclk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // acknowledge is a flop so the host never sees a glitch
    always @(posedge mclk_i) begin
        if (rst_i) begin
            board_write_acknowledge_o <= 1'b0;
        end else begin
            board_write_acknowledge_o <= next_ack; // R7
        end
    end

    // captured byte holds until the next write
    always @(posedge mclk_i) begin
        if (rst_i) begin
            rx_data_o <= `HPW_DATA_RST;
        end else begin
            rx_data_o <= next_rx_data;
        end
    end

    // one-cycle strobe for local logic
    always @(posedge mclk_i) begin
        if (rst_i) begin
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= next_rx_valid;
        end
    end
endmodule // hpw_port
`default_nettype wire

// >>> src/hpw_defines.vh
// Purpose: constants for the host parallel byte write port
// Assumes: one 40 MHz clock
// Notes: included by the port design file only; the synchroniser file does not include it
`ifndef HPW_DEFINES_VH
`define HPW_DEFINES_VH
`define HPW_SEL_W      3
`define HPW_DATA_W     8
`define HPW_SYNC_STAGES 2
`define HPW_ST_IDLE    2'h0
`define HPW_ST_CAPTURE 2'h1
`define HPW_ST_ACK     2'h2
`define HPW_DATA_RST   8'h00
`define HPW_ADDR_RST   3'h0
`endif

// >>> src/hpw_sync.v
// Purpose: two-stage synchroniser for a vector of asynchronous levels
// Assumes: inputs are plain levels from the host link
// Notes: stage one is read only by stage two
`timescale 1ns/1ps
`default_nettype none
module hpw_sync #(
    parameter WIDTH = 1
) (
    input  wire             mclk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] stage_a;
    reg [WIDTH-1:0] stage_b;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : bit_sync
            always @(posedge mclk_i) begin
                if (rst_i) begin
                    stage_a[g] <= 1'b0;
                    stage_b[g] <= 1'b0;
                end else begin
                    stage_a[g] <= async_i[g];
                    stage_b[g] <= stage_a[g];
                end
            end
        end
    endgenerate
    assign sync_o = stage_b;
endmodule // hpw_sync
`default_nettype wire

// >>> dv/hpw_port_checker.sv
// Purpose: port checks. Assumes: 2-flop sync. Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module hpw_chk (input wire logic mclk_i, rst_i, host_request_i, board_write_acknowledge_o,
    rx_valid_o, input wire logic [2:0] board_address_switch_i, board_select_lines_i);
    wire hit = board_select_lines_i == board_address_switch_i, vld = rx_valid_o;
    wire ack = board_write_acknowledge_o, req = host_request_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_take; vld ##1 ack; endsequence
    chk_take_ack: assert property (vld |-> s_take) else $error("no ack");
    chk_ack_holds: assert property (ack && req |=> ack) else $error("ack early");
    chk_ack_cause: assert property ($rose(ack) |-> $past(vld)) else $error("ack cause");
    chk_ack_drop: assert property ($fell(req) |-> ##[1:5] !ack) else $error("ack stuck");
    chk_sync_wait: assert property ($rose(req) |-> !vld ##1 !vld) else $error("no sync");
    chk_sel_match: assert property (vld |-> $past(hit, 2)) else $error("unselected");
endmodule // hpw_chk
bind hpw_port hpw_chk u_chk (.mclk_i, .rst_i, .host_request_i, .board_write_acknowledge_o,
    .rx_valid_o, .board_address_switch_i, .board_select_lines_i);
`default_nettype wire

// >>> dv/hpw_host.sv
// Purpose: host model. Assumes: select from bench. Notes: bus off shows ~byte
`timescale 1ns/1ps
`default_nettype none
module hpw_host (input wire logic mclk_i, go_i, ack_i, input wire logic [7:0] byt_i,
    output logic req_o, output logic [7:0] dat_o);
    logic [1:0] st = 2'h0;
    assign req_o = (st == 2'h1);
    assign dat_o = req_o ? byt_i : ~byt_i;
    always @(posedge mclk_i) case (st)
        2'h0: st <= go_i ? 2'h1 : 2'h0;
        2'h1: st <= (ack_i || !go_i) ? 2'h2 : 2'h1;
        default: st <= ack_i ? 2'h2 : 2'h0;
    endcase
endmodule // hpw_host
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: byte write bench. Assumes: host model. Notes: one clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk_i = 1'b0, rst_i = 1'b1, go = 1'b0, req, ack, vld, bsy;
    logic [2:0] sw = 3'h0, sel = 3'h0;
    logic [7:0] byt = 8'h00, dat, rxd;
    int n_errors = 0, checks_done = 0, n_vld = 0, v0 = 0, i;
    always #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (vld === 1'b1) n_vld <= n_vld + 1;
    hpw_port dut (.mclk_i, .rst_i, .board_address_switch_i(sw), .board_select_lines_i(sel),
        .host_request_i(req), .host_data_i(dat), .board_write_acknowledge_o(ack),
        .rx_data_o(rxd), .rx_valid_o(vld), .busy_o(bsy));
    hpw_host host (.mclk_i, .go_i(go), .ack_i(ack), .byt_i(byt), .req_o(req), .dat_o(dat));
    task chk(input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task wr(input logic [2:0] a, s, input logic [7:0] b, e);
        v0 = n_vld;
        @(posedge mclk_i) {sel, sw, byt, go} <= {a, s, b, 1'b1};
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(negedge mclk_i);
        chk(ack, a == s);
        chk(bsy, a == s);
        chk(rxd, e);
        @(posedge mclk_i) go <= 1'b0;
        for (i = 0; i < 20 && ack !== 1'b0; i++) @(negedge mclk_i);
        if (i == 20) begin n_errors++; finish_test; end
        chk(bsy, 8'h00);
        chk(8'(n_vld - v0), {7'h00, a == s});
    endtask
    task t_reset_state;
        @(negedge mclk_i);
        chk(ack, 8'h00);
        chk(bsy, 8'h00);
        chk(vld, 8'h00);
        chk(rxd, 8'h00);
    endtask
    task t_each_addr; for (int k = 0; k < 8; k++) wr(k[2:0], k[2:0], {5'h1F, k[2:0]}, {5'h1F, k[2:0]}); endtask
    task t_wrong_addr; wr(3'h3, 3'h7, 8'h00, 8'hFF); wr(3'h7, 3'h7, 8'h00, 8'h00); endtask
    initial begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset_state;
        t_each_addr;
        t_wrong_addr;
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
